/* esc_defs.svh */
// Constants for the flash suspend / evaluation / continuity host controller
// Assumes a 16-bit data bus flash and a 22-bit word address
`ifndef ESC_DEFS_SVH
`define ESC_DEFS_SVH

// Host register offsets
`define ESC_OFF_CMD 4'h0
`define ESC_OFF_ADDR 4'h1
`define ESC_OFF_WDATA 4'h2
`define ESC_OFF_STAT 4'h3
`define ESC_OFF_RDATA 4'h4
`define ESC_OFF_CFG 4'h5

// Command codes written to the flash
`define ESC_CD_PAUSE 16'h00b0
`define ESC_CD_RESUME 16'h0030
`define ESC_CD_EVAL 16'h0035
`define ESC_CD_SRCLR 16'h0071
`define ESC_CD_SRRD 16'h0070
`define ESC_CD_RESET 16'h00f0
`define ESC_CD_UNLK1 16'h00aa
`define ESC_CD_UNLK2 16'h0055
`define ESC_CD_IDENT 16'h0090
`define ESC_AD_UNLK1 22'h000555
`define ESC_AD_UNLK2 22'h0002aa

// Continuity patterns, word and byte mode
`define ESC_CC_A1_W 22'h2aaa55
`define ESC_CC_D1_W 16'hff00
`define ESC_CC_A2_W 22'h1555aa
`define ESC_CC_D2_W 16'h00ff
// Byte mode: address includes the lowest bit, data is one byte
`define ESC_CC_A1_B 23'h5554ab
`define ESC_CC_D1_B 8'hff
`define ESC_CC_A2_B 23'h2aab54
`define ESC_CC_D2_B 8'h00

// Status bit positions
`define ESC_SR_READY 7
`define ESC_SR_EVAL_FAIL 5
`define ESC_SR_CONT 0

// Bus timing in ns and cycles at 25 ns
`define ESC_CLK_NS 25
`define ESC_TWP_NS 35
`define ESC_TWP_CYC (((`ESC_TWP_NS) + (`ESC_CLK_NS) - 1) / (`ESC_CLK_NS))
`define ESC_TACC_NS 70
`define ESC_TACC_CYC (((`ESC_TACC_NS) + (`ESC_CLK_NS) - 1) / (`ESC_CLK_NS))
`define ESC_TRTP_NS 20000
`define ESC_TRTP_CYC (((`ESC_TRTP_NS) + (`ESC_CLK_NS) - 1) / (`ESC_CLK_NS))

`endif

/* esc_pkg.sv */
// Types for the flash suspend / evaluation / continuity host controller
// Assumes esc_defs.svh is available for constants
package esc_pkg;
    // Host operations requested by software
    typedef enum logic [3:0] {
        ESC_OP_PAUSE = 4'h1,
        ESC_OP_RESUME = 4'h2,
        ESC_OP_EVAL = 4'h3,
        ESC_OP_CONT = 4'h4,
        ESC_OP_STATUS = 4'h5,
        ESC_OP_IDENT = 4'h6,
        ESC_OP_READ = 4'h7,
        ESC_OP_WRITE = 4'h8,
        ESC_OP_RESET = 4'h9
    } esc_op_e;

    // Flash mode as tracked by the host
    typedef enum logic [2:0] {
        ESC_M_IDLE = 3'h0,
        ESC_M_ERASING = 3'h1,
        ESC_M_PAUSED = 3'h2,
        ESC_M_EVAL = 3'h3,
        ESC_M_BUSY_OTHER = 3'h4
    } esc_mode_e;

    // Sequencer states
    typedef enum logic [2:0] {
        ESC_S_IDLE = 3'h0,
        ESC_S_CYCLE = 3'h1,
        ESC_S_NEXT = 3'h2,
        ESC_S_DONE = 3'h3
    } esc_seq_e;
endpackage

/* esc_bus_cycle.sv */
// Single asynchronous flash bus cycle: write pulse or timed read
// Assumes flash pins are sampled on the 40 MHz clock
`timescale 1ns/100ps
`include "esc_defs.svh"
module esc_bus_cycle (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Cycle request
    input wire logic start,
    input wire logic is_write,
    input wire logic [21:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins
    output logic [21:0] fl_addr,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_ce_n
);
    typedef struct packed {
        logic active;
        logic wr;
        logic [1:0] cnt;
        logic done;
        logic [15:0] rdata;
        logic [21:0] addr;
        logic [15:0] dq;
        logic oe;
        logic we_n;
        logic rd_n;
        logic ce_n;
    } esc_bc_s;
    localparam logic [1:0] WP_LAST = 2'(`ESC_TWP_CYC - 1);
    localparam logic [1:0] ACC_LAST = 2'(`ESC_TACC_CYC - 1);
    esc_bc_s st_reg;
    esc_bc_s st_next;

    // Pulse timing, strobes released on the last count
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (!st_reg.active && start) begin
            st_next.active = 1'b1;
            st_next.wr = is_write;
            st_next.cnt = 2'h0;
            st_next.addr = addr;
            st_next.dq = wdata;
            st_next.oe = is_write;
            st_next.ce_n = 1'b0;
            st_next.we_n = !is_write;
            st_next.rd_n = is_write;
        end else if (st_reg.active) begin
            st_next.cnt = st_reg.cnt + 2'h1;
            if (st_reg.cnt == (st_reg.wr ? WP_LAST : ACC_LAST)) begin
                st_next.active = 1'b0;
                st_next.done = 1'b1;
                st_next.we_n = 1'b1;
                st_next.rd_n = 1'b1;
                st_next.ce_n = 1'b1;
                st_next.oe = 1'b0;
                if (!st_reg.wr) begin
                    st_next.rdata = fl_dq_in;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '{we_n: 1'b1, rd_n: 1'b1, ce_n: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
    assign rdata = st_reg.rdata;
    assign fl_addr = st_reg.addr;
    assign fl_dq_out = st_reg.dq;
    assign fl_dq_oe = st_reg.oe;
    assign fl_we_n = st_reg.we_n;
    assign fl_oe_n = st_reg.rd_n;
    assign fl_ce_n = st_reg.ce_n;

    // Write strobe low only with data driven
    a_we_with_data: assert property (@(posedge clock) disable iff (rst)
        !fl_we_n |-> fl_dq_oe)
        else $error("write strobe without data drive");
    a_one_strobe: assert property (@(posedge clock) disable iff (rst)
        !(!fl_we_n && !fl_oe_n))
        else $error("read and write strobes together");
endmodule

/* esc_guard_timer.sv */
// Counts the least gap from a resume to the next pause
// Assumes one clock domain; restart pulses reload the counter
`timescale 1ns/100ps
`include "esc_defs.svh"
module esc_guard_timer #(
    parameter int GAP_CYC = `ESC_TRTP_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic restart,
    output logic expired
);
    typedef struct packed {
        logic [15:0] cnt;
    } esc_gt_s;
    esc_gt_s st_reg;
    esc_gt_s st_next;

    // Down counter to zero
    always_comb begin
        st_next = st_reg;
        if (restart) begin
            st_next.cnt = 16'(GAP_CYC);
        end else if (st_reg.cnt != 16'h0000) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = (st_reg.cnt == 16'h0000);

    a_gap_reload: assert property (@(posedge clock) disable iff (rst)
        restart |=> !expired) // see RULE_13
        else $error("gap timer not reloaded");
endmodule

/* esc_host.sv */
// Host controller: software registers in, flash command cycles out
// Assumes a 16-bit flash on asynchronous pins and a one-cycle register port
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "esc_defs.svh"
// Operation
// RULE_01: Send B0h to pause sector erase
// RULE_02: Pause only during sector erase or timeout
// RULE_03: No pause during chip erase, program
// RULE_04: Device suspends within pause latency
// RULE_05: Pause in timeout suspends at once
// RULE_06: Paused sectors read back status
// RULE_07: Bit 7, or bits 6 and 2, show pause
// RULE_08: Program in pause returns to pause
// RULE_09: Identification sequence allowed while paused
// RULE_10: Resume to continue, repeats ignored
// RULE_11: Resume code is 30h
// RULE_12: Each pause restarts partial erase step
// RULE_13: Keep minimum gap resume to pause
// RULE_14: Evaluate by 35h at sector when idle
// RULE_15: No evaluation while busy or paused
// RULE_16: Array reads undefined during evaluation
// RULE_17: Bit 7 busy, bit 5 erase result
// RULE_18: Evaluation stops at first bad bit
// RULE_19: Controller returns idle after evaluation
// RULE_20: Word continuity: FF00@2AAA55, 00FF@1555AA
// RULE_21: Byte continuity: FF@5554AB, 00@2AAB54
// RULE_22: Pattern sets status bit zero
// RULE_23: Clear, read, pattern, read status
// RULE_24: Invalid commands leave state unchanged
module esc_host #(
    parameter int GAP_CYC = `ESC_TRTP_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins
    output logic [21:0] fl_addr,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_ce_n
);
    typedef struct packed {
        esc_pkg::esc_seq_e seq;
        esc_pkg::esc_mode_e mode;
        esc_pkg::esc_op_e op;
        logic [2:0] step;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic byte_mode;
        logic refused;
        logic cont_ok;
        logic cont_pre;
        logic eval_fail;
        logic start;
        logic [31:0] rd_out;
    } esc_st_s;
    esc_st_s st_reg;
    esc_st_s st_next;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cyc_is_write;
    logic [21:0] cyc_addr;
    logic [15:0] cyc_data;
    logic [2:0] cyc_last;
    logic gap_ok;
    logic gap_restart;
    // Byte addresses; their lowest bit rides on DQ15 in byte mode
    localparam logic [22:0] CC_A1_B = `ESC_CC_A1_B;
    localparam logic [22:0] CC_A2_B = `ESC_CC_A2_B;

    // Number of the last bus cycle of each operation
    function automatic logic [2:0] op_last(input esc_pkg::esc_op_e op);
        case (op)
            esc_pkg::ESC_OP_CONT: op_last = 3'h6;
            esc_pkg::ESC_OP_IDENT: op_last = 3'h3;
            esc_pkg::ESC_OP_STATUS: op_last = 3'h1;
            default: op_last = 3'h0;
        endcase
    endfunction

    // Whether the tracked mode allows the operation
    function automatic logic op_allowed(input esc_pkg::esc_op_e op,
                                        input esc_pkg::esc_mode_e m, input logic gap);
        case (op)
            esc_pkg::ESC_OP_PAUSE: op_allowed = (m == esc_pkg::ESC_M_ERASING) && gap;
            esc_pkg::ESC_OP_RESUME: op_allowed = (m == esc_pkg::ESC_M_PAUSED);
            esc_pkg::ESC_OP_EVAL: op_allowed = (m == esc_pkg::ESC_M_IDLE); // see RULE_15
            esc_pkg::ESC_OP_IDENT: op_allowed = (m == esc_pkg::ESC_M_PAUSED) ||
                                                (m == esc_pkg::ESC_M_IDLE);
            esc_pkg::ESC_OP_READ: op_allowed = (m != esc_pkg::ESC_M_EVAL);
            esc_pkg::ESC_OP_CONT, esc_pkg::ESC_OP_STATUS, esc_pkg::ESC_OP_WRITE,
            esc_pkg::ESC_OP_RESET: op_allowed = 1'b1;
            default: op_allowed = 1'b0;
        endcase
    endfunction

    // Address, data and direction of each bus cycle
    always_comb begin
        cyc_is_write = 1'b1;
        cyc_addr = st_reg.addr;
        cyc_data = st_reg.wdata;
        cyc_last = op_last(st_reg.op);
        case (st_reg.op)
            esc_pkg::ESC_OP_PAUSE: cyc_data = `ESC_CD_PAUSE; // see RULE_01
            esc_pkg::ESC_OP_RESUME: cyc_data = `ESC_CD_RESUME; // see RULE_11
            esc_pkg::ESC_OP_EVAL: cyc_data = `ESC_CD_EVAL; // see RULE_14
            esc_pkg::ESC_OP_RESET: cyc_data = `ESC_CD_RESET;
            esc_pkg::ESC_OP_READ: cyc_is_write = 1'b0;
            esc_pkg::ESC_OP_STATUS: begin
                cyc_addr = `ESC_AD_UNLK1;
                cyc_data = `ESC_CD_SRRD;
                cyc_is_write = (st_reg.step == 3'h0);
            end
            esc_pkg::ESC_OP_IDENT: begin
                // Unlock, unlock, id code, read - see RULE_09
                cyc_addr = (st_reg.step == 3'h1) ? `ESC_AD_UNLK2 : `ESC_AD_UNLK1;
                cyc_data = (st_reg.step == 3'h0) ? `ESC_CD_UNLK1 :
                           (st_reg.step == 3'h1) ? `ESC_CD_UNLK2 : `ESC_CD_IDENT;
                if (st_reg.step == 3'h3) begin
                    cyc_addr = st_reg.addr;
                    cyc_is_write = 1'b0;
                end
            end
            esc_pkg::ESC_OP_CONT: begin
                // Clear, status read, two patterns, status read
                case (st_reg.step)
                    3'h0: begin
                        cyc_addr = `ESC_AD_UNLK1;
                        cyc_data = `ESC_CD_SRCLR; // see RULE_23
                    end
                    3'h1, 3'h5: begin
                        cyc_addr = `ESC_AD_UNLK1;
                        cyc_data = `ESC_CD_SRRD;
                    end
                    3'h3: begin
                        cyc_addr = st_reg.byte_mode ? CC_A1_B[22:1] : `ESC_CC_A1_W; // see RULE_21
                        cyc_data = st_reg.byte_mode ? {CC_A1_B[0], 7'h00, `ESC_CC_D1_B} :
                                   `ESC_CC_D1_W; // see RULE_20
                    end
                    3'h4: begin
                        cyc_addr = st_reg.byte_mode ? CC_A2_B[22:1] : `ESC_CC_A2_W; // see RULE_21
                        cyc_data = st_reg.byte_mode ? {CC_A2_B[0], 7'h00, `ESC_CC_D2_B} :
                                   `ESC_CC_D2_W; // see RULE_20
                    end
                    default: cyc_is_write = 1'b0;
                endcase
            end
            default: cyc_is_write = 1'b1;
        endcase
    end

    // Register writes, sequencing and mode tracking
    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.rd_out = 32'h0000_0000;
        gap_restart = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                `ESC_OFF_STAT: st_next.rd_out = {24'h000000, st_reg.cont_ok,
                    st_reg.eval_fail, st_reg.refused, (st_reg.seq != esc_pkg::ESC_S_IDLE),
                    1'b0, st_reg.mode};
                `ESC_OFF_RDATA: st_next.rd_out = {16'h0000, st_reg.rdata};
                `ESC_OFF_ADDR: st_next.rd_out = {10'h000, st_reg.addr};
                `ESC_OFF_WDATA: st_next.rd_out = {16'h0000, st_reg.wdata};
                `ESC_OFF_CFG: st_next.rd_out = {31'h0, st_reg.byte_mode};
                default: st_next.rd_out = 32'h0000_0000;
            endcase
        end
        if (reg_wr && st_reg.seq == esc_pkg::ESC_S_IDLE) begin
            case (reg_addr)
                `ESC_OFF_ADDR: st_next.addr = reg_wdata[21:0];
                `ESC_OFF_WDATA: st_next.wdata = reg_wdata[15:0];
                `ESC_OFF_CFG: begin
                    st_next.byte_mode = reg_wdata[0];
                    // Software reports erase start/finish: 1 erase, 2 idle, 3 other busy
                    if (reg_wdata[5:4] == 2'h1) st_next.mode = esc_pkg::ESC_M_ERASING;
                    if (reg_wdata[5:4] == 2'h2) st_next.mode = esc_pkg::ESC_M_IDLE;
                    if (reg_wdata[5:4] == 2'h3) st_next.mode = esc_pkg::ESC_M_BUSY_OTHER;
                end
                `ESC_OFF_CMD: begin
                    if (op_allowed(esc_pkg::esc_op_e'(reg_wdata[3:0]), st_reg.mode, gap_ok)) begin
                        st_next.op = esc_pkg::esc_op_e'(reg_wdata[3:0]);
                        st_next.step = 3'h0;
                        st_next.seq = esc_pkg::ESC_S_CYCLE;
                        st_next.start = 1'b1;
                        st_next.refused = 1'b0;
                    end else begin
                        // Invalid in this mode: nothing goes to the flash, see RULE_15
                        st_next.refused = 1'b1; // see RULE_03
                    end
                end
                default: st_next.refused = st_reg.refused;
            endcase
        end
        case (st_reg.seq)
            esc_pkg::ESC_S_IDLE: st_next.seq = st_next.seq;
            esc_pkg::ESC_S_CYCLE: begin
                if (cyc_done) begin
                    if (!cyc_is_write) begin
                        st_next.rdata = cyc_rdata;
                    end
                    if (st_reg.step == cyc_last) begin
                        st_next.seq = esc_pkg::ESC_S_DONE;
                    end else begin
                        st_next.seq = esc_pkg::ESC_S_NEXT;
                    end
                end
            end
            esc_pkg::ESC_S_NEXT: begin
                st_next.step = st_reg.step + 3'h1;
                st_next.start = 1'b1;
                st_next.seq = esc_pkg::ESC_S_CYCLE;
            end
            esc_pkg::ESC_S_DONE: begin
                st_next.seq = esc_pkg::ESC_S_IDLE;
                case (st_reg.op)
                    esc_pkg::ESC_OP_PAUSE: st_next.mode = esc_pkg::ESC_M_PAUSED; // see RULE_02
                    esc_pkg::ESC_OP_RESUME: begin
                        st_next.mode = esc_pkg::ESC_M_ERASING; // see RULE_10
                        gap_restart = 1'b1; // see RULE_13
                    end
                    esc_pkg::ESC_OP_EVAL: st_next.mode = esc_pkg::ESC_M_EVAL;
                    esc_pkg::ESC_OP_RESET: st_next.mode = esc_pkg::ESC_M_IDLE;
                    esc_pkg::ESC_OP_STATUS: begin
                        // Evaluation over once ready shows, see RULE_19
                        st_next.eval_fail = st_reg.rdata[`ESC_SR_EVAL_FAIL]; // see RULE_17
                        if (st_reg.mode == esc_pkg::ESC_M_EVAL &&
                            st_reg.rdata[`ESC_SR_READY]) begin
                            st_next.mode = esc_pkg::ESC_M_IDLE;
                        end
                    end
                    esc_pkg::ESC_OP_CONT: begin
                        // Bit zero must have risen since the first read, see RULE_22
                        st_next.cont_ok = st_reg.rdata[`ESC_SR_CONT] && !st_reg.cont_pre;
                    end
                    default: st_next.mode = st_reg.mode;
                endcase
            end
            default: st_next.seq = esc_pkg::ESC_S_IDLE;
        endcase
        // Continuity: first status read must show bit zero clear
        if (st_reg.seq == esc_pkg::ESC_S_CYCLE && cyc_done &&
            st_reg.op == esc_pkg::ESC_OP_CONT && st_reg.step == 3'h2) begin
            st_next.cont_ok = 1'b0;
            st_next.cont_pre = cyc_rdata[`ESC_SR_CONT]; // see RULE_23
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '{seq: esc_pkg::ESC_S_IDLE, mode: esc_pkg::ESC_M_IDLE,
                        op: esc_pkg::ESC_OP_READ, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    esc_bus_cycle u_cycle (
        .clock(clock),
        .rst(rst),
        .start(st_reg.start),
        .is_write(cyc_is_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_in(fl_dq_in),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n),
        .fl_ce_n(fl_ce_n)
    );

    esc_guard_timer #(.GAP_CYC(GAP_CYC)) u_gap (
        .clock(clock),
        .rst(rst),
        .restart(gap_restart),
        .expired(gap_ok)
    );

    assign reg_rdata = st_reg.rd_out;

    // Checks
    a_pause_code: assert property (@(posedge clock) disable iff (rst)
        (!fl_we_n && st_reg.op == esc_pkg::ESC_OP_PAUSE) |-> fl_dq_out == 16'h00b0) // see RULE_01
        else $error("pause code wrong");
    a_resume_code: assert property (@(posedge clock) disable iff (rst)
        (!fl_we_n && st_reg.op == esc_pkg::ESC_OP_RESUME) |-> fl_dq_out == 16'h0030) // see RULE_11
        else $error("resume code wrong");
    a_eval_idle: assert property (@(posedge clock) disable iff (rst)
        (st_reg.start && st_reg.op == esc_pkg::ESC_OP_EVAL && st_reg.step == 3'h0)
        |-> $past(st_reg.mode) == esc_pkg::ESC_M_IDLE) // see RULE_15
        else $error("evaluation started while not idle");
    a_pause_gap: assert property (@(posedge clock) disable iff (rst)
        (st_reg.start && st_reg.op == esc_pkg::ESC_OP_PAUSE) |-> $past(gap_ok)) // see RULE_13
        else $error("pause too soon after resume");
    a_pause_mode: assert property (@(posedge clock) disable iff (rst)
        (st_reg.seq == esc_pkg::ESC_S_DONE && st_reg.op == esc_pkg::ESC_OP_PAUSE)
        |=> st_reg.mode == esc_pkg::ESC_M_PAUSED) // see RULE_02
        else $error("pause not tracked");
    a_no_read_eval: assert property (@(posedge clock) disable iff (rst)
        (st_reg.mode == esc_pkg::ESC_M_EVAL) |-> !(st_reg.start &&
        st_reg.op == esc_pkg::ESC_OP_READ)) // see RULE_16
        else $error("array read during evaluation");
    a_cont_first: assert property (@(posedge clock) disable iff (rst)
        (!fl_we_n && st_reg.op == esc_pkg::ESC_OP_CONT && st_reg.step == 3'h3 &&
        !st_reg.byte_mode) |-> fl_addr == 22'h2aaa55 && fl_dq_out == 16'hff00) // see RULE_20
        else $error("first continuity cycle wrong");
    a_cont_byte: assert property (@(posedge clock) disable iff (rst)
        (!fl_we_n && st_reg.op == esc_pkg::ESC_OP_CONT && st_reg.step == 3'h4 &&
        st_reg.byte_mode) |-> fl_addr == 22'h1555aa && fl_dq_out == 16'h0000) // see RULE_21
        else $error("second byte continuity cycle wrong");
    a_refuse_hold: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == 4'h0 && st_reg.seq == esc_pkg::ESC_S_IDLE &&
        !op_allowed(esc_pkg::esc_op_e'(reg_wdata[3:0]), st_reg.mode, gap_ok))
        |=> st_reg.refused && $stable(st_reg.mode) && !st_reg.start) // see RULE_24
        else $error("refused command altered state");
    c_pause: cover property (@(posedge clock) st_reg.mode == esc_pkg::ESC_M_PAUSED);
    c_eval: cover property (@(posedge clock) st_reg.mode == esc_pkg::ESC_M_EVAL);
    c_cont: cover property (@(posedge clock) st_reg.cont_ok);
    c_refused: cover property (@(posedge clock) st_reg.refused);
endmodule

/* esc_flash_model.sv */
// Flash device model: status register, evaluation timer, continuity detector
// Assumes the host's registered strobes, sampled on the host clock
`timescale 1ns/100ps
`include "esc_defs.svh"
module esc_flash_model #(
    parameter bit EVAL_FAIL = 1'b1
) (
    // Host side pins
    input wire logic clock,
    input wire logic [21:0] fl_addr,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_ce_n,
    output logic [15:0] fl_dq_in,
    // Last completed write, for the bench
    output logic [21:0] wr_a,
    output logic [15:0] wr_d
);
    logic [7:0] sr = 8'h80;
    logic [2:0] ecnt = 3'h0;
    logic [15:0] last = 16'h0;
    logic [21:0] a = 22'h0;
    logic [15:0] d = 16'h0;
    logic we_q = 1'b1;
    // Reads give status; released bus shows the inverse
    assign fl_dq_in = (!fl_oe_n && !fl_ce_n) ? {8'h00, sr} : ~last;
    // Pause, resume, ident need no state here
    // Pause takes effect at once, no erase progress kept
    always @(posedge clock) begin
        we_q <= fl_we_n;
        if (!fl_we_n) begin
            a <= fl_addr;
            d <= fl_dq_out;
        end
        if (!fl_oe_n) last <= fl_dq_in;
        if (ecnt != 3'h0) ecnt <= ecnt - 3'h1;
        if (ecnt == 3'h1) sr <= {1'b1, sr[6], EVAL_FAIL, sr[4:0]};
        if (fl_we_n && !we_q) begin
            wr_a <= a;
            wr_d <= d;
            if (d[7:0] == 8'h71) sr[0] <= 1'b0;
            if (d[7:0] == 8'h35) begin
                sr[7] <= 1'b0;
                ecnt <= 3'h4;
            end
            if ({wr_a, wr_d, a, d} == {`ESC_CC_A1_W, `ESC_CC_D1_W, `ESC_CC_A2_W, `ESC_CC_D2_W}
                || {wr_a, wr_d[15], wr_d[7:0], a, d[15], d[7:0]} ==
                {`ESC_CC_A1_B, `ESC_CC_D1_B, `ESC_CC_A2_B, `ESC_CC_D2_B})
                sr[0] <= 1'b1;
        end
    end
endmodule

/* tb_esc_host.sv */
// Testbench for the flash host controller against the flash model
// Assumes a 40 MHz clock and the register map of the host
`timescale 1ns/100ps
`include "esc_defs.svh"
module tb_esc_host;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] v;
    logic [21:0] fl_addr, wr_a;
    logic [15:0] fl_dq_out, fl_dq_in, wr_d;
    logic fl_dq_oe, fl_we_n, fl_oe_n, fl_ce_n;
    int n_fail = 0;
    int comparisons = 0;
    esc_host #(.GAP_CYC(40)) i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n));
    esc_flash_model i_flash (.clock(clock), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
        .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n), .fl_dq_in(fl_dq_in),
        .wr_a(wr_a), .wr_d(wr_d));
    // Clock at 25 ns
    initial begin
        forever #12.5 clock = ~clock;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Register read, data taken in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Issue an operation, poll busy, return status masked
    task automatic op(input logic [3:0] code);
        wr(`ESC_OFF_CMD, {28'h0, code});
        for (int i = 0; i < 60; i++) begin
            rd(`ESC_OFF_STAT);
            if (v[4] === 1'b0) break;
        end
        if (v[4] !== 1'b0) begin
            n_fail++;
            $display("[FAIL] %0t busy poll ran out", $time);
        end
        v = v & 32'hff;
    endtask
    // Verdict and end of run
    task automatic wrap_up;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (6000) @(posedge clock);
        n_fail++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(4'hf);
        chk(v, 32'h0);
        op(4'h1);
        chk(v, 32'h20);
        wr(`ESC_OFF_CFG, 32'h10);
        repeat (45) @(posedge clock);
        op(4'h1);
        chk(v, 32'h02);
        chk({16'h0, wr_d}, 32'hb0);
        op(4'h3);
        chk(v, 32'h22);
        op(4'h2);
        chk(v, 32'h01);
        chk({16'h0, wr_d}, 32'h30);
        op(4'h2);
        chk(v, 32'h21);
        op(4'h1);
        chk(v, 32'h21);
        repeat (45) @(posedge clock);
        op(4'h1);
        chk(v, 32'h02);
        op(4'h6);
        chk(v, 32'h02);
        wr(`ESC_OFF_WDATA, 32'h1234);
        wr(`ESC_OFF_ADDR, 32'h000100);
        op(4'h8);
        chk(v, 32'h02);
        chk({10'h0, wr_a}, 32'h000100);
        chk({16'h0, wr_d}, 32'h1234);
        op(4'h9);
        chk(v, 32'h00);
        chk({16'h0, wr_d}, 32'hf0);
        wr(`ESC_OFF_CFG, 32'h30);
        op(4'h1);
        chk(v, 32'h24);
        wr(`ESC_OFF_CFG, 32'h20);
        wr(`ESC_OFF_ADDR, 32'h0abcde);
        op(4'h3);
        chk(v, 32'h03);
        chk({10'h0, wr_a}, 32'h0abcde);
        chk({16'h0, wr_d}, 32'h35);
        op(4'h7);
        chk(v, 32'h23);
        repeat (10) @(posedge clock);
        op(4'h5);
        chk(v & 32'h47, 32'h40);
        op(4'h4);
        chk(v & 32'h80, 32'h80);
        wr(`ESC_OFF_CFG, 32'h21);
        op(4'h4);
        chk(v & 32'h80, 32'h80);
        wrap_up();
    end
endmodule
